// *** core/cbm_pkg.sv ***
// package: register map, field layout and reset values of the cross-bus event block
package cbm_pkg;
    localparam int CBM_AW = 12;
    localparam int CBM_DW = 32;
    // register byte offsets within the 4 Kbyte register space
    localparam logic [11:0] CBM_LINT_EN = 12'h300;
    localparam logic [11:0] CBM_LINT_STAT = 12'h304;
    localparam logic [11:0] CBM_VINT_EN = 12'h310;
    localparam logic [11:0] CBM_VINT_STAT = 12'h314;
    localparam logic [11:0] CBM_LINT_MAP2 = 12'h340;
    localparam logic [11:0] CBM_VINT_MAP2 = 12'h344;
    localparam logic [11:0] CBM_MAILBOX_0 = 12'h348;
    localparam logic [11:0] CBM_SEMA_0 = 12'h358;
    localparam logic [11:0] CBM_SEMA_1 = 12'h35c;
    localparam logic [11:0] CBM_LOC_CTL = 12'hf64;
    localparam logic [11:0] CBM_LOC_BASE = 12'hf68;
    // shared field positions in enable and status registers
    localparam int CBM_MBOX_POS = 16;
    localparam int CBM_LOC_POS = 20;
    localparam int CBM_SWI_POS = 24;
    // location monitor control and base register fields
    localparam int CBM_LOC_EN_POS = 31;
    localparam int CBM_LOC_VAS_POS = 16;
    localparam int CBM_LOC_AM_POS = 0;
    localparam int CBM_LOC_BASE_POS = 12;
    // address widths of the location image
    localparam logic [1:0] CBM_VAS_A16 = 2'h0;
    localparam logic [1:0] CBM_VAS_A24 = 2'h1;
    localparam logic [1:0] CBM_VAS_A32 = 2'h2;
    localparam logic [31:0] CBM_RESET_VAL = 32'h0000_0000;
    typedef enum logic [1:0] {CBM_IDLE, CBM_REQ, CBM_DONE} cbm_bus_state_t;
endpackage

// *** core/cbm_link_if.sv ***
// interface: register access and vme cycle link between host controller and bridge core
`timescale 1ns/1ps
interface cbm_link_if;
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    // vme cycle observed on the backplane
    logic vme_valid;
    logic [31:0] vme_addr;
    logic [5:0] vme_am;
    logic vme_block;
    logic vme_addr_only;
    logic vme_own;
    logic vme_dtack;
    logic [7:0] pci_irq;
    logic [7:1] vme_irq;
    modport dev (input cyc, stb, we, sel, adr, wdat, vme_valid, vme_addr, vme_am,
        vme_block, vme_addr_only, vme_own,
        output rdat, ack, vme_dtack, pci_irq, vme_irq);
    modport ctl (output cyc, stb, we, sel, adr, wdat, vme_valid, vme_addr, vme_am,
        vme_block, vme_addr_only, vme_own,
        input rdat, ack, vme_dtack, pci_irq, vme_irq);
endinterface

// *** core/cbm_irq_route.sv ***
// module: routes one group of event lines onto interrupt outputs through 3-bit maps
`timescale 1ns/1ps
module cbm_irq_route #(
    parameter int N = 4,
    parameter int LINES = 8,
    parameter int BASE = 0
) (
    input wire logic [N-1:0] act_i,
    input wire logic [3*N-1:0] map_i,
    output logic [LINES-1:0] irq_o
);
    always_comb
    begin
        irq_o = '0;
        for (int i = 0; i < N; i++)
        begin
            // vme levels run 1..7, so map code 0 on the vme side asserts nothing
            if (act_i[i] && (int'(map_i[3*i +: 3]) >= BASE))
                irq_o[int'(map_i[3*i +: 3]) - BASE] = 1'b1;
        end
    end
endmodule

// *** core/cbm_core.sv ***
// module: bridge end holding mailboxes, location monitor, software irqs and semaphores
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module cbm_core
    import cbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    cbm_link_if.dev link,
    output logic [3:0] loc_event_o
);
    // ****************************************
    // registers
    // ****************************************
    logic [31:0] mbox_q [4];
    logic [31:0] lint_en_q;
    logic [31:0] vint_en_q;
    logic [3:0] mbox_l_q;
    logic [3:0] mbox_v_q;
    logic [3:0] loc_q;
    logic [6:0] swi_q;
    logic [31:0] lmap2_q;
    logic [31:0] vmap2_q;
    logic [31:0] loc_ctl_q;
    logic [31:0] loc_base_q;
    logic [7:0] sema_q [8];
    logic ack_q;
    logic [31:0] rdat_q;
    logic dtack_q;
    logic acc;
    logic wr;
    logic [3:0] mb_wr;
    logic [3:0] loc_hit;
    logic [31:0] wmask;
    logic [31:0] lstat;
    logic [31:0] vstat;

    // ****************************************
    // bus slave: answers one cycle after request, ack drops after one
    // ****************************************
    assign acc = link.cyc && link.stb && !ack_q && ce_i;
    // writes land on the ack edge, the one at which the master samples ack
    assign wr = link.cyc && link.stb && link.we && ack_q && ce_i;
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[8*b +: 8] = {8{link.sel[b]}};
    end
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            mb_wr[i] = wr && (link.adr == CBM_MAILBOX_0 + 12'(4*i));
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else if (ce_i)
            ack_q <= acc;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 4; i++)
                mbox_q[i] <= CBM_RESET_VAL;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                if (mb_wr[i])
                    mbox_q[i] <= (mbox_q[i] & ~wmask) | (link.wdat & wmask);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lint_en_q <= CBM_RESET_VAL;
            vint_en_q <= CBM_RESET_VAL;
            lmap2_q <= CBM_RESET_VAL;
            vmap2_q <= CBM_RESET_VAL;
            loc_ctl_q <= CBM_RESET_VAL;
            loc_base_q <= CBM_RESET_VAL;
        end
        else if (wr)
        begin
            unique case (link.adr)
                CBM_LINT_EN: lint_en_q <= (lint_en_q & ~wmask) | (link.wdat & wmask);
                CBM_VINT_EN: vint_en_q <= (vint_en_q & ~wmask) | (link.wdat & wmask);
                CBM_LINT_MAP2: lmap2_q <= (lmap2_q & ~wmask) | (link.wdat & wmask);
                CBM_VINT_MAP2: vmap2_q <= (vmap2_q & ~wmask) | (link.wdat & wmask);
                CBM_LOC_CTL: loc_ctl_q <= (loc_ctl_q & ~wmask) | (link.wdat & wmask);
                CBM_LOC_BASE: loc_base_q <= (loc_base_q & ~wmask) | (link.wdat & wmask);
                default: ;
            endcase
        end
    end

    // ****************************************
    // semaphores: one byte lane per semaphore
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 8; i++)
                sema_q[i] <= 8'h00;
        end
        else if (wr && (link.adr == CBM_SEMA_0 || link.adr == CBM_SEMA_1))
        begin
            for (int b = 0; b < 4; b++)
            begin
                // a held semaphore only takes a release; free ones take anything
                if (link.sel[b] && (!sema_q[(link.adr[2] ? 4 : 0) + b][7]
                    || !link.wdat[8*b + 7]))
                    sema_q[(link.adr[2] ? 4 : 0) + b] <= link.wdat[8*b +: 8];
            end
        end
    end

    // ****************************************
    // location monitor
    // ****************************************
    logic img_hit;
    always_comb
    begin
        unique case (loc_ctl_q[CBM_LOC_VAS_POS +: 2])
            CBM_VAS_A16: img_hit = link.vme_addr[15:12] == loc_base_q[15:12];
            CBM_VAS_A24: img_hit = link.vme_addr[23:12] == loc_base_q[23:12];
            default: img_hit = link.vme_addr[31:12] == loc_base_q[31:CBM_LOC_BASE_POS];
        endcase
        img_hit = img_hit && loc_ctl_q[CBM_LOC_EN_POS] && link.vme_valid
            && link.vme_am == loc_ctl_q[CBM_LOC_AM_POS +: 6]
            && !link.vme_block && !link.vme_addr_only;
        loc_hit = img_hit ? (4'h1 << link.vme_addr[4:3]) : 4'h0;
    end
    assign loc_event_o = loc_hit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dtack_q <= 1'b0;
        else if (ce_i)
            dtack_q <= img_hit && link.vme_own;
    end

    // ****************************************
    // sticky status: set wins over write-one clear
    // ****************************************
    logic lclr;
    logic vclr;
    assign lclr = wr && link.adr == CBM_LINT_STAT;
    assign vclr = wr && link.adr == CBM_VINT_STAT;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mbox_l_q <= 4'h0;
            mbox_v_q <= 4'h0;
            loc_q <= 4'h0;
        end
        else if (ce_i)
        begin
            mbox_l_q <= (mbox_l_q & ~({4{lclr}} & link.wdat[CBM_MBOX_POS +: 4] & {4{link.sel[2]}}))
                | (mb_wr & lint_en_q[CBM_MBOX_POS +: 4]);
            mbox_v_q <= (mbox_v_q & ~({4{vclr}} & link.wdat[CBM_MBOX_POS +: 4] & {4{link.sel[2]}}))
                | (mb_wr & vint_en_q[CBM_MBOX_POS +: 4]);
            loc_q <= (loc_q & ~({4{lclr}} & link.wdat[CBM_LOC_POS +: 4] & {4{link.sel[2]}}))
                | (loc_hit & lint_en_q[CBM_LOC_POS +: 4]);
        end
    end
    // status copy of the software levels, one cycle behind the pins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            swi_q <= 7'h00;
        else if (ce_i)
            swi_q <= vint_en_q[CBM_SWI_POS +: 7];
    end

    assign lstat = {24'h0, 8'h0} | (32'(mbox_l_q) << CBM_MBOX_POS) | (32'(loc_q) << CBM_LOC_POS);
    assign vstat = (32'(mbox_v_q) << CBM_MBOX_POS) | (32'(swi_q) << CBM_SWI_POS);

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_q <= CBM_RESET_VAL;
        else if (acc && !link.we)
        begin
            unique case (link.adr)
                CBM_LINT_EN: rdat_q <= lint_en_q;
                CBM_LINT_STAT: rdat_q <= lstat;
                CBM_VINT_EN: rdat_q <= vint_en_q;
                CBM_VINT_STAT: rdat_q <= vstat;
                CBM_LINT_MAP2: rdat_q <= lmap2_q;
                CBM_VINT_MAP2: rdat_q <= vmap2_q;
                CBM_MAILBOX_0: rdat_q <= mbox_q[0];
                CBM_MAILBOX_0 + 12'h004: rdat_q <= mbox_q[1];
                CBM_MAILBOX_0 + 12'h008: rdat_q <= mbox_q[2];
                CBM_MAILBOX_0 + 12'h00c: rdat_q <= mbox_q[3];
                CBM_SEMA_0: rdat_q <= {sema_q[3], sema_q[2], sema_q[1], sema_q[0]};
                CBM_SEMA_1: rdat_q <= {sema_q[7], sema_q[6], sema_q[5], sema_q[4]};
                CBM_LOC_CTL: rdat_q <= loc_ctl_q;
                CBM_LOC_BASE: rdat_q <= loc_base_q;
                default: rdat_q <= CBM_RESET_VAL;
            endcase
        end
    end

    // ****************************************
    // interrupt routing
    // ****************************************
    logic [7:0] p_mb;
    logic [7:0] p_lm;
    logic [6:0] v_mb;
    cbm_irq_route #(.N(4), .LINES(8), .BASE(0)) i_cbm_irq_route_pmb (
        .act_i(mbox_l_q), .map_i({lmap2_q[14:12], lmap2_q[10:8], lmap2_q[6:4], lmap2_q[2:0]}),
        .irq_o(p_mb));
    cbm_irq_route #(.N(4), .LINES(8), .BASE(0)) i_cbm_irq_route_plm (
        .act_i(loc_q), .map_i({lmap2_q[30:28], lmap2_q[26:24], lmap2_q[22:20], lmap2_q[18:16]}),
        .irq_o(p_lm));
    cbm_irq_route #(.N(4), .LINES(7), .BASE(1)) i_cbm_irq_route_vmb (
        .act_i(mbox_v_q), .map_i({vmap2_q[14:12], vmap2_q[10:8], vmap2_q[6:4], vmap2_q[2:0]}),
        .irq_o(v_mb));

    assign link.pci_irq = p_mb | p_lm;
    // software levels drive their pins straight from the enable register
    assign link.vme_irq = v_mb | vint_en_q[CBM_SWI_POS +: 7];
    assign link.ack = ack_q;
    assign link.rdat = rdat_q;
    assign link.vme_dtack = dtack_q;
endmodule

// *** core/cbm_ctl.sv ***
// module: host end turning user requests into classic bus cycles and passing vme cycle inputs through to the link
`timescale 1ns/1ps
module cbm_ctl
    import cbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    cbm_link_if.ctl link,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] wdat_i,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] rdat_o,
    input wire logic vme_valid_i,
    input wire logic [31:0] vme_addr_i,
    input wire logic [5:0] vme_am_i,
    input wire logic vme_block_i,
    input wire logic vme_addr_only_i,
    input wire logic vme_own_i,
    output logic vme_dtack_o,
    output logic [7:0] pci_irq_o,
    output logic [7:1] vme_irq_o
);
    cbm_bus_state_t st_q;
    logic [31:0] rdat_q;
    logic done_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= CBM_IDLE;
            link.cyc <= 1'b0;
            link.stb <= 1'b0;
            link.we <= 1'b0;
            link.sel <= 4'h0;
            link.adr <= 12'h000;
            link.wdat <= CBM_RESET_VAL;
            rdat_q <= CBM_RESET_VAL;
            done_q <= 1'b0;
        end
        else if (ce_i)
        begin
            done_q <= 1'b0;
            unique case (st_q)
                CBM_IDLE:
                    if (req_i)
                    begin
                        // semaphores should be driven one byte lane at a time
                        link.cyc <= 1'b1;
                        link.stb <= 1'b1;
                        link.we <= we_i;
                        link.sel <= sel_i;
                        link.adr <= adr_i;
                        link.wdat <= wdat_i;
                        st_q <= CBM_REQ;
                    end
                CBM_REQ:
                    if (link.ack)
                    begin
                        link.cyc <= 1'b0;
                        link.stb <= 1'b0;
                        rdat_q <= link.rdat;
                        done_q <= 1'b1;
                        st_q <= CBM_DONE;
                    end
                CBM_DONE:
                    st_q <= CBM_IDLE;
            endcase
        end
    end

    assign busy_o = st_q != CBM_IDLE;
    assign done_o = done_q;
    assign rdat_o = rdat_q;
    assign link.vme_valid = vme_valid_i;
    assign link.vme_addr = vme_addr_i;
    assign link.vme_am = vme_am_i;
    assign link.vme_block = vme_block_i;
    assign link.vme_addr_only = vme_addr_only_i;
    assign link.vme_own = vme_own_i;
    assign vme_dtack_o = link.vme_dtack;
    assign pci_irq_o = link.pci_irq;
    assign vme_irq_o = link.vme_irq;
endmodule

// *** sim/cbm_sva.sv ***
// checker: timing properties on the link between host end and bridge core
`timescale 1ns/1ps
module cbm_sva
    import cbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [11:0] adr,
    input wire logic [31:0] wdat,
    input wire logic [31:0] rdat,
    input wire logic ack,
    input wire logic vme_valid,
    input wire logic vme_block,
    input wire logic vme_addr_only,
    input wire logic vme_own,
    input wire logic vme_dtack,
    input wire logic [7:0] pci_irq,
    input wire logic [7:1] vme_irq
);
    // ****************
    // properties
    // ****************
    logic [6:0] swi_w;
    assign swi_w = wdat[30:24];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        cyc && stb && !ack |=> ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        ack |-> $past(cyc && stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_dtack_cause;
        vme_dtack |-> $past(vme_valid && vme_own && !vme_block && !vme_addr_only);
    endproperty
    a_dtack_cause: assert property (p_dtack_cause) else $error("dtack unowned");
    property p_dtack_ignored;
        vme_valid && (vme_block || vme_addr_only) |=> !vme_dtack;
    endproperty
    a_dtack_ignored: assert property (p_dtack_ignored) else $error("dtack on block");
    // a hit may land while the read is in flight, so those cycles are excluded
    property p_read_quiet;
        ack && !we && !vme_valid && !$past(vme_valid) |=> $stable(pci_irq) && $stable(vme_irq);
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read raised irq");
    property p_irq_cause;
        $rose(|pci_irq) |-> (ack && we) || $past(ack && we) || $past(vme_valid)
            || $past(vme_valid, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq uncaused");
    property p_swi_direct;
        ack && we && adr == CBM_VINT_EN |=> (vme_irq & $past(swi_w)) == $past(swi_w);
    endproperty
    a_swi_direct: assert property (p_swi_direct) else $error("swi level missing");
    property p_rdat_hold;
        !(cyc && stb && !we) |=> $stable(rdat);
    endproperty
    a_rdat_hold: assert property (p_rdat_hold) else $error("rdat moved");
    c_mbox: cover property (ack && we && adr == CBM_MAILBOX_0);
    c_dtack: cover property (vme_dtack);
    c_swi: cover property (|vme_irq);
endmodule

// *** sim/cbm_tb.sv ***
// testbench: both ends joined over the link, driven from the host request side
`timescale 1ns/1ps
module cbm_tb
    import cbm_pkg::*;
();
    // ****************
    // harness
    // ****************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic req_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic [11:0] adr_i = 12'h000;
    logic [31:0] wdat_i = 32'h0;
    logic vme_valid_i = 1'b0;
    logic [31:0] vme_addr_i = 32'h0;
    logic [5:0] vme_am_i = 6'h00;
    logic vme_block_i = 1'b0;
    logic vme_addr_only_i = 1'b0;
    logic vme_own_i = 1'b0;
    logic busy_o, done_o, vme_dtack_o;
    logic [31:0] rdat_o;
    logic [7:0] pci_irq_o;
    logic [7:1] vme_irq_o;
    logic [3:0] loc_event_o;
    int fails = 0;
    int samples_checked = 0;
    int dt;
    logic [3:0] ev;
    cbm_link_if link ();
    cbm_core i_cbm_core (.clk_i, .rst_i, .ce_i, .link(link), .loc_event_o);
    cbm_ctl i_cbm_ctl (.clk_i, .rst_i, .ce_i, .link(link), .req_i, .we_i, .sel_i,
        .adr_i, .wdat_i, .busy_o, .done_o, .rdat_o, .vme_valid_i, .vme_addr_i, .vme_am_i,
        .vme_block_i, .vme_addr_only_i, .vme_own_i, .vme_dtack_o, .pci_irq_o, .vme_irq_o);
    cbm_sva i_cbm_sva (.clk_i, .rst_i, .cyc(link.cyc), .stb(link.stb), .we(link.we),
        .adr(link.adr), .wdat(link.wdat), .rdat(link.rdat), .ack(link.ack),
        .vme_valid(link.vme_valid), .vme_block(link.vme_block),
        .vme_addr_only(link.vme_addr_only), .vme_own(link.vme_own),
        .vme_dtack(link.vme_dtack), .pci_irq(link.pci_irq), .vme_irq(link.vme_irq));
    initial
        forever #2.5 clk_i = ~clk_i;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ****************
    // drivers
    // ****************
    task automatic bus(input logic w, input logic [3:0] s, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk_i);
        req_i <= 1'b1;
        we_i <= w;
        sel_i <= s;
        adr_i <= a;
        wdat_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (done_o !== 1'b1 && n < 20);
        if (done_o !== 1'b1)
        begin
            fails++;
            $display("[FAIL] t=%0t bus timeout got=%h exp=%h", $time, done_o, 1'b1);
            print_verdict();
        end
        // busy covers the CBM_DONE cycle after ack, then drops
        chk(busy_o, 32'h1);
        @(negedge clk_i);
        chk(busy_o, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, 4'hf, a, 32'h0);
        chk(rdat_o, exp);
    endtask
    // one backplane cycle, then dtack pulses and events are gathered over a window
    task automatic vme(input logic [31:0] a, input logic [5:0] m, input logic b,
            input logic o, input logic own);
        @(posedge clk_i);
        vme_valid_i <= 1'b1;
        vme_addr_i <= a;
        vme_am_i <= m;
        vme_block_i <= b;
        vme_addr_only_i <= o;
        vme_own_i <= own;
        dt = 0;
        ev = 4'h0;
        repeat (5)
        begin
            @(negedge clk_i);
            dt = dt + int'(vme_dtack_o === 1'b1);
            ev = ev | loc_event_o;
            @(posedge clk_i);
            vme_valid_i <= 1'b0;
            vme_addr_i <= ~a;
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_mbox();
        bus(1'b1, 4'hf, CBM_LINT_MAP2, 32'h3210_7531);
        bus(1'b1, 4'hf, CBM_VINT_MAP2, 32'h0000_4321);
        bus(1'b1, 4'hf, CBM_MAILBOX_0, 32'h1234_5678);
        rd(CBM_LINT_STAT, 32'h0);
        bus(1'b1, 4'hf, CBM_LINT_EN, 32'h00ff_0000);
        bus(1'b1, 4'hf, CBM_VINT_EN, 32'h000f_0000);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 4'hf, CBM_MAILBOX_0 + 12'(4 * i), 32'hc0de_0000 | i);
            chk(pci_irq_o, 32'h1 << (2 * i + 1));
            chk(vme_irq_o, 32'h1 << i);
            rd(CBM_LINT_STAT, 32'h1 << (16 + i));
            rd(CBM_VINT_STAT, 32'h1 << (16 + i));
            rd(CBM_MAILBOX_0 + 12'(4 * i), 32'hc0de_0000 | i);
            chk(pci_irq_o, 32'h1 << (2 * i + 1));
            bus(1'b1, 4'hf, CBM_LINT_STAT, 32'h1 << (16 + i));
            bus(1'b1, 4'hf, CBM_VINT_STAT, 32'h1 << (16 + i));
            chk({pci_irq_o, vme_irq_o}, 32'h0);
        end
        $display("mailbox test done");
    endtask
    task automatic t_loc();
        bus(1'b1, 4'hf, CBM_LOC_BASE, 32'h00ab_c000);
        bus(1'b1, 4'hf, CBM_LOC_CTL, 32'h8001_0039);
        for (int i = 0; i < 4; i++)
        begin
            vme(32'h00ab_c000 | (i << 3), 6'h39, 1'b0, 1'b0, 1'b1);
            chk(dt, 32'h1);
            chk(ev, 32'h1 << i);
            chk(pci_irq_o, 32'h1 << i);
            rd(CBM_LINT_STAT, 32'h1 << (20 + i));
            bus(1'b1, 4'hf, CBM_LINT_STAT, 32'h1 << (20 + i));
        end
        // frozen clock enable: a hit is neither answered nor recorded
        @(posedge clk_i);
        ce_i <= 1'b0;
        vme(32'h00ab_c000, 6'h39, 1'b0, 1'b0, 1'b1);
        chk(dt, 32'h0);
        ce_i <= 1'b1;
        rd(CBM_LINT_STAT, 32'h0);
        // block, address-only, foreign code, outside the window
        for (int k = 0; k < 4; k++)
        begin
            vme(k == 3 ? 32'h00ab_d000 : 32'h00ab_c000, k == 2 ? 6'h3d : 6'h39,
                k == 0, k == 1, 1'b1);
            chk(dt + ev, 32'h0);
        end
        rd(CBM_LINT_STAT, 32'h0);
        vme(32'h00ab_c018, 6'h39, 1'b0, 1'b0, 1'b0);
        chk(dt, 32'h0);
        rd(CBM_LINT_STAT, 32'h1 << 23);
        bus(1'b1, 4'hf, CBM_LINT_STAT, 32'h1 << 23);
        bus(1'b1, 4'hf, CBM_LOC_CTL, 32'h0001_0039);
        vme(32'h00ab_c000, 6'h39, 1'b0, 1'b0, 1'b1);
        chk(ev, 32'h0);
        // same base seen through the a32 and a16 decodes
        bus(1'b1, 4'hf, CBM_LOC_CTL, 32'h8002_0039);
        vme(32'h01ab_c008, 6'h39, 1'b0, 1'b0, 1'b1);
        chk(ev, 32'h0);
        vme(32'h00ab_c008, 6'h39, 1'b0, 1'b0, 1'b1);
        chk(ev, 32'h2);
        bus(1'b1, 4'hf, CBM_LOC_CTL, 32'h8000_0039);
        vme(32'h55ff_c010, 6'h39, 1'b0, 1'b0, 1'b1);
        chk(ev, 32'h4);
        rd(CBM_LINT_STAT, 32'h0060_0000);
        bus(1'b1, 4'hf, CBM_LINT_STAT, 32'h0060_0000);
        $display("location test done");
    endtask
    task automatic t_swi();
        for (int l = 1; l < 8; l++)
        begin
            bus(1'b1, 4'hf, CBM_VINT_EN, 32'h1 << (23 + l));
            chk(vme_irq_o, 32'h1 << (l - 1));
            rd(CBM_VINT_STAT, 32'h1 << (23 + l));
        end
        bus(1'b1, 4'hf, CBM_VINT_EN, 32'h0);
        chk(vme_irq_o, 32'h0);
        $display("software irq test done");
    endtask
    task automatic t_sema();
        rd(CBM_SEMA_0, 32'h0);
        rd(CBM_SEMA_1, 32'h0);
        bus(1'b1, 4'h2, CBM_SEMA_0, 32'h0000_a500);
        rd(CBM_SEMA_0, 32'h0000_a500);
        bus(1'b1, 4'h2, CBM_SEMA_0, 32'h0000_9300);
        rd(CBM_SEMA_0, 32'h0000_a500);
        bus(1'b1, 4'h2, CBM_SEMA_0, 32'h0000_1300);
        rd(CBM_SEMA_0, 32'h0000_1300);
        bus(1'b1, 4'h2, CBM_SEMA_0, 32'h0000_9300);
        bus(1'b1, 4'h8, CBM_SEMA_1, 32'h8100_0000);
        rd(CBM_SEMA_1, 32'h8100_0000);
        rd(CBM_SEMA_0, 32'h0000_9300);
        bus(1'b1, 4'hf, 12'h400, 32'hffff_ffff);
        rd(12'h400, 32'h0);
        $display("semaphore test done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_sema();
        t_mbox();
        t_loc();
        t_swi();
        print_verdict();
    end
endmodule
